// ### hw/wcrc_map.svh
// Offsets, timing counts and frame constants of the write CRC checker
`ifndef WCRC_MAP_SVH
`define WCRC_MAP_SVH

// Device command clock period in ps
`define WCRC_CLK_PERIOD_PS  5000
// Longest error to alert latency in ns, and its floor in clocks
`define WCRC_ALERT_LAT_NS   13
`define WCRC_ALERT_LAT_CYC  ((`WCRC_ALERT_LAT_NS * 1000) / `WCRC_CLK_PERIOD_PS)
// Alert pulse width bounds in clocks, and the width used
`define WCRC_ALERT_PW_MIN   4'd6
`define WCRC_ALERT_PW_MAX   4'd10
`define WCRC_ALERT_PW       4'd8
// Frame lengths in transfers, minus one
`define WCRC_LAST_CRC       4'd9
`define WCRC_LAST_PLAIN     4'd7
// Idle link clocks ahead of each frame, minus one
`define WCRC_PRE_LAST       4'd1
// Link lanes: nine per byte group, the ninth is the mask/inversion lane
`define WCRC_LANES          18
`define WCRC_GRP_LANES      9
// CRC-8 generator x^8 + x^2 + x + 1
`define WCRC_CRC_POLY       8'h07

`endif

// ### hw/wcrc_pkg.sv
// Types and shared CRC functions of the write CRC checker
package wcrc_pkg;
	`include "wcrc_map.svh"

	typedef enum logic [1:0] {
		WCRC_X4  = 2'b00,
		WCRC_X8  = 2'b01,
		WCRC_X16 = 2'b10
	} wcrc_org_t;

	typedef enum logic [1:0] {
		WCRC_IDLE = 2'b00,
		WCRC_PRE  = 2'b01,
		WCRC_SEND = 2'b10
	} wcrc_tx_st_t;

	// One frame: ten transfers of eighteen lanes
	typedef logic [9:0][17:0] wcrc_frame_t;

	// Device link side state
	typedef struct packed {
		logic [6:0]  cfg_s1;
		logic [6:0]  cfg_s2;
		logic [3:0]  cnt;
		logic        bc4;
		logic        nib;
		wcrc_frame_t frame;
		logic        done_tgl;
		logic        err_tgl;
		logic        blocked;
	} wcrc_dlk_t;

	// Device command clock side state
	typedef struct packed {
		logic [2:0]   dn;
		logic [2:0]   er;
		logic [2:0]   cl;
		logic         valid;
		logic         blocked;
		logic [143:0] data;
		logic         clr_bit;
		logic         stat_bit;
		logic         pend;
		logic [3:0]   acnt;
		logic         drive;
	} wcrc_dck_t;

	// Controller state
	typedef struct packed {
		wcrc_tx_st_t  st;
		logic         ph;
		logic [3:0]   cnt;
		wcrc_frame_t  frame;
		logic [17:0]  dq;
		logic         valid;
		logic         bc4;
		logic         nib;
		logic [143:0] last_data;
		logic         last_bc4;
		logic         last_nib;
		logic         last_ok;
		logic         retry;
		logic [2:0]   al;
		logic [6:0]   mr;
		logic         clr_tgl;
		logic         seen;
	} wcrc_ctl_t;

	// Serial form of the 72-bit CRC-8 tree, highest bit first, zero seed
	function automatic logic [7:0] wcrc_crc8(input logic [71:0] d);
		logic [7:0] c;
		logic       fb;
		c = 8'h00;
		for (int i = 71; i >= 0; i--) begin
			fb = c[7] ^ d[i];
			c  = {c[6:0], 1'b0} ^ (fb ? `WCRC_CRC_POLY : 8'h00);
		end
		return c;
	endfunction : wcrc_crc8

	// Tree inputs of byte group g; unused positions are forced to one
	function automatic logic [71:0] wcrc_tree(input wcrc_frame_t f, input logic g, input wcrc_org_t org,
		input logic bc4, input logic mask_en);
		logic [71:0] d;
		logic        used;
		int          base;
		d    = '1;
		base = g ? `WCRC_GRP_LANES : 0;
		for (int k = 0; k < 9; k++) begin
			case (org)
				WCRC_X4: used = !g && (k < 4);
				WCRC_X8: used = !g && ((k < 8) || mask_en);
				default: used = (k < 8) || mask_en;
			endcase
			// A chopped beat lands in the low nibble positions, whichever
			// half of the byte it carries; the high positions stay ones
			for (int t = 0; t < 8; t++) begin
				if (used && (!bc4 || (t < 4)))
					d[8*k+t] = f[t][base+k];
			end
		end
		return d;
	endfunction : wcrc_tree

	// CRC bits as carried in transfer 8 for group g, or in transfers 8 and 9 on x4
	function automatic logic [7:0] wcrc_rx_crc(input wcrc_frame_t f, input logic g, input wcrc_org_t org);
		if (org == WCRC_X4)
			return {f[9][3:0], f[8][3:0]};
		return g ? f[8][`WCRC_GRP_LANES +: 8] : f[8][7:0];
	endfunction : wcrc_rx_crc
endpackage : wcrc_pkg

// ### hw/wcrc_if.sv
// Write data link and open-drain alert line between controller and device
`timescale 1ns/1ps
interface wcrc_if;
	logic        lclk;
	logic        lk_valid;
	logic        lk_bc4;
	logic        lk_nib;
	logic [17:0] lk_dq;
	logic        alert_o;
	logic        alert_oe_n;
	logic        alert_n;
	logic        mr_crc_en;
	logic        mr_otf_en;
	logic        mr_bc4_fix;
	logic        mr_dm_en;
	logic        mr_dbi_en;
	logic [1:0]  mr_org;
	logic        mr_clr_tgl;

	// Pulled up unless the device enables its driver
	assign alert_n = alert_oe_n ? 1'b1 : alert_o;

	modport dev (
		input  lclk, lk_valid, lk_bc4, lk_nib, lk_dq, alert_n,
		input  mr_crc_en, mr_otf_en, mr_bc4_fix, mr_dm_en, mr_dbi_en, mr_org, mr_clr_tgl,
		output alert_o, alert_oe_n
	);
	modport ctl (
		output lclk, lk_valid, lk_bc4, lk_nib, lk_dq,
		output mr_crc_en, mr_otf_en, mr_bc4_fix, mr_dm_en, mr_dbi_en, mr_org, mr_clr_tgl,
		input  alert_n
	);
endinterface : wcrc_if

// ### hw/wcrc_dev.sv
// Device end: frame capture, CRC check, error bits and alert pulse
`timescale 1ns/1ps
module wcrc_dev
	import wcrc_pkg::*;
(
	input  wire logic     clk_i,
	input  wire logic     rstn_i,
	wcrc_if.dev           lk,
	output logic          wr_valid_o,
	output logic [143:0]  wr_data_o,
	output logic          wr_blocked_o,
	output logic          mode_register_five_clr_o,
	output logic          readout_page_status_reg_o
);

	wcrc_dlk_t lq_r;
	wcrc_dlk_t lq_nxt;
	wcrc_dck_t cq_r;
	wcrc_dck_t cq_nxt;

	////////////////////////////////////////////////////////////////////////////
	// Link side, on the controller's link clock

	// Decoded settings after the two-stage crossing; they settle during the
	// two preamble edges ahead of each frame
	logic      cfg_crc_en;
	logic      cfg_otf;
	logic      cfg_bc4_fix;
	logic      cfg_dm;
	logic      cfg_mask_en;
	wcrc_org_t cfg_org;
	logic [3:0] last_beat;
	logic      crc_bad;
	logic      bad_lo;
	logic      bad_hi;
	wcrc_frame_t cur_frame;

	assign cfg_crc_en  = lq_r.cfg_s2[6];
	assign cfg_otf     = lq_r.cfg_s2[5];
	assign cfg_bc4_fix = lq_r.cfg_s2[4];
	assign cfg_dm      = lq_r.cfg_s2[3];
	assign cfg_mask_en = lq_r.cfg_s2[3] | lq_r.cfg_s2[2];
	assign cfg_org     = wcrc_org_t'(lq_r.cfg_s2[1:0]);
	// Ten transfers with CRC on, eight without
	assign last_beat   = cfg_crc_en ? `WCRC_LAST_CRC : `WCRC_LAST_PLAIN;

	// One tree's verdict: computed check bits against those carried in the frame
	function automatic logic tree_bad(input wcrc_frame_t f, input logic g, input wcrc_org_t org,
		input logic bc4, input logic mask_en);
		logic [7:0] calc;
		logic [7:0] rcvd;
		calc = wcrc_crc8(wcrc_tree(f, g, org, bc4, mask_en));
		rcvd = wcrc_rx_crc(f, g, org);
		return calc != rcvd;
	endfunction : tree_bad

	// Frame as it stands after this edge: stored beats plus the one on the lanes,
	// so the verdict needs no further link edge and no loop through lq_nxt
	always_comb begin
		cur_frame           = lq_r.frame;
		cur_frame[lq_r.cnt] = lk.lk_dq;
	end

	// Mismatch on either tree; the upper tree counts only on x16, and nothing
	// counts with checking off
	always_comb begin
		bad_lo  = tree_bad(cur_frame, 1'b0, cfg_org, lq_r.bc4, cfg_mask_en);
		bad_hi  = tree_bad(cur_frame, 1'b1, cfg_org, lq_r.bc4, cfg_mask_en);
		crc_bad = cfg_crc_en && (bad_lo || ((cfg_org == WCRC_X16) && bad_hi));
	end

	// Capture transfers; the verdict is taken on the last edge, since the
	// link clock may stop right after it. Chopped frames keep the full length
	always_comb begin
		lq_nxt        = lq_r;
		lq_nxt.cfg_s1 = {lk.mr_crc_en, lk.mr_otf_en, lk.mr_bc4_fix, lk.mr_dm_en, lk.mr_dbi_en, lk.mr_org};
		lq_nxt.cfg_s2 = lq_r.cfg_s1;
		if (lk.lk_valid) begin
			if (lq_r.cnt == 4'd0) begin
				lq_nxt.bc4 = cfg_otf ? lk.lk_bc4 : cfg_bc4_fix;
				lq_nxt.nib = lk.lk_nib;
			end
			lq_nxt.frame[lq_r.cnt] = lk.lk_dq;
			if (lq_r.cnt >= last_beat) begin
				lq_nxt.cnt      = 4'd0;
				lq_nxt.done_tgl = ~lq_r.done_tgl;
				lq_nxt.err_tgl  = lq_r.err_tgl ^ crc_bad;
				lq_nxt.blocked  = crc_bad & cfg_dm;
			end else begin
				lq_nxt.cnt = lq_r.cnt + 4'd1;
			end
		end
	end

	// Link registers; reset cannot wait for the link clock, which stands
	// still whenever no frame is out
	always_ff @(posedge lk.lclk or negedge rstn_i) begin
		if (!rstn_i) begin
			lq_r <= '0;
		end else begin
			lq_r <= lq_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Command clock side

	logic done_evt;
	logic err_evt;
	logic clr_evt;
	logic pend_any;

	assign done_evt = cq_r.dn[2] ^ cq_r.dn[1];
	assign err_evt  = cq_r.er[2] ^ cq_r.er[1];
	assign clr_evt  = cq_r.cl[2] ^ cq_r.cl[1];
	assign pend_any = cq_r.pend | err_evt;

	// Event crossings, hand-over of the frame, error bits and alert timing.
	// Frame words stay put on the link side until the next frame starts, which
	// is far longer than the toggle crossing takes.
	always_comb begin
		cq_nxt       = cq_r;
		cq_nxt.dn    = {cq_r.dn[1:0], lq_r.done_tgl};
		cq_nxt.er    = {cq_r.er[1:0], lq_r.err_tgl};
		cq_nxt.cl    = {cq_r.cl[1:0], lk.mr_clr_tgl};
		cq_nxt.valid = 1'b0;
		if (done_evt) begin
			cq_nxt.valid   = ~lq_r.blocked;
			cq_nxt.blocked = lq_r.blocked;
			for (int g = 0; g < 2; g++) begin
				for (int k = 0; k < 9; k++) begin
					for (int t = 0; t < 8; t++) begin
						cq_nxt.data[72*g+8*k+t] = lq_r.frame[t][`WCRC_GRP_LANES*g+k];
					end
				end
			end
		end
		// Clear first so that an error in the same cycle wins
		if (clr_evt) begin
			cq_nxt.clr_bit  = 1'b0;
			cq_nxt.stat_bit = 1'b0;
		end
		if (err_evt) begin
			cq_nxt.clr_bit  = 1'b1;
			cq_nxt.stat_bit = 1'b1;
		end
		// Pulse starts on the edge after the error shows here, three clocks after the last link edge,
		// beyond the 13 ns latency limit; a second error waits for a released gap
		if ((cq_r.acnt == 4'd0) && pend_any) begin
			cq_nxt.acnt = `WCRC_ALERT_PW + 4'd1;
			cq_nxt.pend = 1'b0;
		end else begin
			cq_nxt.pend = pend_any;
			if (cq_r.acnt != 4'd0)
				cq_nxt.acnt = cq_r.acnt - 4'd1;
		end
		cq_nxt.drive = cq_nxt.acnt > 4'd1;
	end

	// Command clock registers
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cq_r <= '0;
		end else begin
			cq_r <= cq_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	// Alert is only ever pulled low, never driven high
	assign lk.alert_o    = 1'b0;
	assign lk.alert_oe_n = ~cq_r.drive;
	assign wr_valid_o    = cq_r.valid;
	assign wr_data_o     = cq_r.data;
	assign wr_blocked_o  = cq_r.blocked;
	assign mode_register_five_clr_o  = cq_r.clr_bit;
	assign readout_page_status_reg_o = cq_r.stat_bit;

endmodule : wcrc_dev

// ### hw/wcrc_ctl.sv
// Controller end: frame builder, link clock divider, alert watch and retry
`timescale 1ns/1ps
module wcrc_ctl
	import wcrc_pkg::*;
(
	input  wire logic          clk_i,
	input  wire logic          rstn_i,
	wcrc_if.ctl                lk,
	input  wire logic          wr_valid_i,
	output logic               wr_ready_o,
	input  wire logic [143:0]  wr_data_i,
	input  wire logic          wr_bc4_i,
	input  wire logic          chop_nibble_select_i,
	input  wire logic          wr_corrupt_i,
	input  wire logic          crc_en_i,
	input  wire logic          otf_en_i,
	input  wire logic          bc4_fix_i,
	input  wire logic          dm_en_i,
	input  wire logic          dbi_en_i,
	input  wire logic [1:0]    org_i,
	input  wire logic          err_clr_i,
	output logic               alert_seen_o,
	output logic               busy_o
);

	wcrc_ctl_t q_r;
	wcrc_ctl_t q_nxt;

	// Settings as last latched while idle
	wcrc_org_t  org;
	logic [3:0] last_beat;
	logic       alert_fall;
	logic       start;
	logic       new_bc4;

	assign org        = wcrc_org_t'(q_r.mr[1:0]);
	assign last_beat  = q_r.mr[6] ? `WCRC_LAST_CRC : `WCRC_LAST_PLAIN;
	assign alert_fall = q_r.al[2] & ~q_r.al[1];
	assign new_bc4    = q_r.mr[5] ? wr_bc4_i : q_r.mr[4];

	////////////////////////////////////////////////////////////////////////////
	// Frame builder

	// Data, padding ones and CRC placement for one write
	function automatic wcrc_frame_t build(input logic [143:0] d, input logic bc4, input logic nib,
		input logic bad);
		wcrc_frame_t f;
		logic [7:0]  c0;
		logic [7:0]  c1;
		f = '1;
		for (int g = 0; g < 2; g++) begin
			for (int k = 0; k < 9; k++) begin
				for (int t = 0; t < 8; t++) begin
					if (!bc4)
						f[t][`WCRC_GRP_LANES*g+k] = d[72*g+8*k+t];
					else if (t < 4)
						f[t][`WCRC_GRP_LANES*g+k] = d[72*g+8*k+4*int'(nib)+t];
				end
			end
		end
		c0 = wcrc_crc8(wcrc_tree(f, 1'b0, org, bc4, q_r.mr[3] | q_r.mr[2]));
		c1 = wcrc_crc8(wcrc_tree(f, 1'b1, org, bc4, q_r.mr[3] | q_r.mr[2]));
		c0 = c0 ^ {7'h00, bad};
		if (q_r.mr[6]) begin
			for (int k = 0; k < 8; k++) begin
				if (org == WCRC_X4) begin
					if (k < 4) begin
						f[8][k] = c0[k];
						f[9][k] = c0[k+4];
					end
				end else begin
					f[8][k] = c0[k];
					if (org == WCRC_X16)
						f[8][`WCRC_GRP_LANES+k] = c1[k];
				end
			end
		end
		return f;
	endfunction : build

	////////////////////////////////////////////////////////////////////////////
	// Sequencer

	assign start = (q_r.st == WCRC_IDLE) && ((q_r.retry && q_r.last_ok) || wr_valid_i);

	// Link clock is clk_i halved while a frame is out; data moves on its fall
	always_comb begin
		q_nxt      = q_r;
		q_nxt.al   = {q_r.al[1:0], lk.alert_n};
		q_nxt.seen = alert_fall;
		if (err_clr_i)
			q_nxt.clr_tgl = ~q_r.clr_tgl;
		case (q_r.st)
			WCRC_IDLE: begin
				q_nxt.ph = 1'b0;
				q_nxt.mr = {crc_en_i, otf_en_i, bc4_fix_i, dm_en_i, dbi_en_i, org_i};
				if (q_r.retry && q_r.last_ok) begin
					// Retry goes first so rewritten data lands in order
					q_nxt.retry = 1'b0;
					q_nxt.frame = build(q_r.last_data, q_r.last_bc4, q_r.last_nib, 1'b0);
					q_nxt.bc4   = q_r.last_bc4;
					q_nxt.nib   = q_r.last_nib;
				end else if (wr_valid_i) begin
					q_nxt.frame     = build(wr_data_i, new_bc4, chop_nibble_select_i, wr_corrupt_i);
					q_nxt.bc4       = new_bc4;
					q_nxt.nib       = chop_nibble_select_i;
					q_nxt.last_data = wr_data_i;
					q_nxt.last_bc4  = new_bc4;
					q_nxt.last_nib  = chop_nibble_select_i;
					q_nxt.last_ok   = 1'b1;
				end
				if (start) begin
					q_nxt.st  = WCRC_PRE;
					q_nxt.cnt = 4'd0;
				end
			end
			WCRC_PRE: begin
				q_nxt.ph = ~q_r.ph;
				if (q_r.ph) begin
					if (q_r.cnt == `WCRC_PRE_LAST) begin
						q_nxt.st    = WCRC_SEND;
						q_nxt.cnt   = 4'd0;
						q_nxt.valid = 1'b1;
						q_nxt.dq    = q_r.frame[0];
					end else begin
						q_nxt.cnt = q_r.cnt + 4'd1;
					end
				end
			end
			WCRC_SEND: begin
				q_nxt.ph = ~q_r.ph;
				if (q_r.ph) begin
					if (q_r.cnt >= last_beat) begin
						q_nxt.st    = WCRC_IDLE;
						q_nxt.valid = 1'b0;
						q_nxt.dq    = '1;
					end else begin
						q_nxt.cnt = q_r.cnt + 4'd1;
						q_nxt.dq  = q_r.frame[q_r.cnt + 4'd1];
					end
				end
			end
			default: begin
				q_nxt.st = WCRC_IDLE;
			end
		endcase
		// An alert asks for the last write again; set wins over the take
		if (alert_fall && q_r.last_ok)
			q_nxt.retry = 1'b1;
	end

	// Controller registers
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			q_r    <= '0;
			q_r.al <= 3'b111;
			q_r.dq <= '1;
		end else begin
			q_r <= q_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign lk.lclk       = q_r.ph;
	assign lk.lk_valid   = q_r.valid;
	assign lk.lk_bc4     = q_r.bc4;
	assign lk.lk_nib     = q_r.nib;
	assign lk.lk_dq      = q_r.dq;
	assign lk.mr_crc_en  = q_r.mr[6];
	assign lk.mr_otf_en  = q_r.mr[5];
	assign lk.mr_bc4_fix = q_r.mr[4];
	assign lk.mr_dm_en   = q_r.mr[3];
	assign lk.mr_dbi_en  = q_r.mr[2];
	assign lk.mr_org     = q_r.mr[1:0];
	assign lk.mr_clr_tgl = q_r.clr_tgl;
	assign wr_ready_o    = (q_r.st == WCRC_IDLE) && !(q_r.retry && q_r.last_ok);
	assign alert_seen_o  = q_r.seen;
	assign busy_o        = q_r.st != WCRC_IDLE;

endmodule : wcrc_ctl

// ### bench/wcrc_chk.sv
// Assertions on the write link and alert line between the two ends
`timescale 1ns/1ps
module wcrc_chk (
	input wire logic        clk_i,
	input wire logic        rstn_i,
	input wire logic        lclk,
	input wire logic        lk_valid,
	input wire logic        lk_bc4,
	input wire logic [17:0] lk_dq,
	input wire logic        alert_o,
	input wire logic        alert_oe_n,
	input wire logic        alert_n,
	input wire logic        mr_crc_en,
	input wire logic        mr_otf_en,
	input wire logic [1:0]  mr_org
);
	logic [4:0] vcnt_r;
	logic [3:0] scnt_r;

	////////////////////////////////////////////////////////////////
	// Cycles in frame, and idle cycles since frame end (saturating)
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			vcnt_r <= 5'h00;
			scnt_r <= 4'h0;
		end else begin
			vcnt_r <= lk_valid ? vcnt_r + 5'h01 : 5'h00;
			scnt_r <= lk_valid ? 4'h0 : (scnt_r == 4'hf ? scnt_r : scnt_r + 4'h1);
		end
	end

	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);

	property p_width;
		$fell(alert_n) |-> (!alert_n)[*8] ##1 alert_n;
	endproperty
	a_width: assert property (p_width) else $error("alert pulse width wrong");
	property p_drive;
		!alert_oe_n |-> !alert_o;
	endproperty
	a_drive: assert property (p_drive) else $error("alert driven high");
	property p_len;
		$fell(lk_valid) |-> vcnt_r == (mr_crc_en ? 5'h14 : 5'h10);
	endproperty
	a_len: assert property (p_len) else $error("frame length wrong");
	property p_uiclk;
		lk_valid && $past(lk_valid) |-> lclk != $past(lclk);
	endproperty
	a_uiclk: assert property (p_uiclk) else $error("link clock stalled in frame");
	property p_pad;
		lk_valid && mr_crc_en && lk_bc4 && mr_otf_en && vcnt_r[4:3] == 2'b01 |-> &lk_dq;
	endproperty
	a_pad: assert property (p_pad) else $error("chop padding not ones");
	property p_t9;
		lk_valid && mr_crc_en && mr_org != 2'b00 && vcnt_r >= 5'h12 |-> &lk_dq;
	endproperty
	a_t9: assert property (p_t9) else $error("last transfer not ones");
	property p_mlane;
		lk_valid && mr_crc_en && mr_org == 2'b10 && vcnt_r >= 5'h10 |-> lk_dq[8] && lk_dq[17];
	endproperty
	a_mlane: assert property (p_mlane) else $error("mask lanes not ones");
	property p_x4;
		lk_valid && mr_crc_en && mr_org == 2'b00 && vcnt_r >= 5'h10 |-> &lk_dq[17:4];
	endproperty
	a_x4: assert property (p_x4) else $error("unused lanes not ones");
	property p_lat;
		$fell(alert_n) |-> scnt_r <= 4'h6;
	endproperty
	a_lat: assert property (p_lat) else $error("alert too late");

	// Main scenarios reached
	c_alert: cover property ($fell(alert_n));
	c_chop: cover property (lk_valid && lk_bc4 && mr_otf_en);
	c_x16: cover property ($fell(lk_valid) && mr_org == 2'b10);
endmodule : wcrc_chk

// ### bench/tb_top.sv
// Self-checking bench joining controller and device ends
`timescale 1ns/1ps
module tb_top
	import wcrc_pkg::*;
;
	logic         clk_i = 1'b0, rstn_i = 1'b0, wr_valid = 1'b0, wr_bc4 = 1'b0, nib_sel = 1'b0;
	logic         corrupt = 1'b0, crc_en = 1'b0, otf_en = 1'b0, bc4_fix = 1'b0, err_clr = 1'b0;
	logic         dm_en = 1'b0, dbi_en = 1'b0;
	logic [1:0]   org = 2'b00;
	logic [143:0] wr_data = '0;
	logic         ready, alert_seen, busy, dv, blocked, clr_bit, stat_bit;
	logic [143:0] dv_data;
	int           error_cnt = 0, cmp_count = 0, cyc = 0, nval, nal, nblk, nlow;

	wcrc_if lk_if();
	wcrc_dev wcrc_dev_inst (.clk_i(clk_i), .rstn_i(rstn_i), .lk(lk_if), .wr_valid_o(dv), .wr_data_o(dv_data),
		.wr_blocked_o(blocked), .mode_register_five_clr_o(clr_bit), .readout_page_status_reg_o(stat_bit));
	wcrc_ctl wcrc_ctl_inst (.clk_i(clk_i), .rstn_i(rstn_i), .lk(lk_if), .wr_valid_i(wr_valid),
		.wr_ready_o(ready), .wr_data_i(wr_data), .wr_bc4_i(wr_bc4), .chop_nibble_select_i(nib_sel),
		.wr_corrupt_i(corrupt), .crc_en_i(crc_en), .otf_en_i(otf_en), .bc4_fix_i(bc4_fix), .dm_en_i(dm_en),
		.dbi_en_i(dbi_en), .org_i(org), .err_clr_i(err_clr), .alert_seen_o(alert_seen), .busy_o(busy));
	wcrc_chk wcrc_chk_inst (.clk_i(clk_i), .rstn_i(rstn_i), .lclk(lk_if.lclk), .lk_valid(lk_if.lk_valid),
		.lk_bc4(lk_if.lk_bc4), .lk_dq(lk_if.lk_dq), .alert_o(lk_if.alert_o), .alert_oe_n(lk_if.alert_oe_n),
		.alert_n(lk_if.alert_n), .mr_crc_en(lk_if.mr_crc_en), .mr_otf_en(lk_if.mr_otf_en), .mr_org(lk_if.mr_org));

	////////////////////////////////////////////////////////////////
	// 200 MHz clock
	initial begin
		forever #2.5 clk_i = ~clk_i;
	end

	// Hang guard, far above the few hundred cycles needed
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			stop_test();
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [143:0] got, input logic [143:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test

	// Config only between frames; the idle cycle lets the controller latch it
	task automatic cfg(input logic [1:0] o, input logic c, f, x, dm, db);
		@(negedge clk_i);
		org = o;
		crc_en = c;
		otf_en = f;
		bc4_fix = x;
		dm_en = dm;
		dbi_en = db;
		@(negedge clk_i);
	endtask : cfg

	// One write, retry included; judges pulse count and captured data
	task automatic wr(input logic [143:0] d, input logic b, n, bad, input int ev);
		logic [143:0] e;
		logic [143:0] m;
		logic         ch;
		ch = otf_en ? b : bc4_fix;
		e = '1;
		m = '0;
		for (int l = 0; l < 18; l++) begin
			for (int t = 0; t < 8; t++) begin
				m[8*l+t] = (l % 9 < 8 || dm_en || dbi_en) && (org == WCRC_X16 || l < (org == WCRC_X8 ? 9 : 4));
				e[8*l+t] = !ch ? d[8*l+t] : (t < 4 ? d[8*l+4*n+t] : 1'b1);
			end
		end
		nval = 0;
		nal = 0;
		nblk = 0;
		nlow = 0;
		@(negedge clk_i);
		wr_valid = 1'b1;
		wr_data = d;
		wr_bc4 = b;
		nib_sel = n;
		corrupt = bad;
		@(negedge clk_i);
		wr_valid = 1'b0;
		corrupt = 1'b0;
		for (int i = 0; i < 200; i++) begin
			@(negedge clk_i);
			nval += dv;
			nal += alert_seen;
			nblk += blocked;
			nlow += !lk_if.alert_n;
			if (nval == ev && !busy && ready && lk_if.alert_n)
				break;
		end
		chk(144'(nval), 144'(ev));
		chk(dv_data & m, e & m);
	endtask : wr

	////////////////////////////////////////////////////////////////
	// Every organisation, full and chopped, both nibbles, mask lane on and off
	task automatic t_map();
		for (int o = 0; o < 3; o++) begin
			for (int v = 0; v < 4; v++) begin
				cfg(2'(o), 1'b1, 1'b1, 1'b0, v[1], v == 1);
				wr({9{16'h5a3c + 16'(o * 4 + v)}}, v[0], v[1], 1'b0, 1);
				chk(144'(nlow), 144'h0);
			end
		end
		$display("t_map finished");
	endtask : t_map

	// Bad CRC: alert, sticky bits, retry; with masking the bad write is dropped
	task automatic t_err();
		for (int b = 0; b < 2; b++) begin
			cfg(b ? WCRC_X16 : WCRC_X8, 1'b1, 1'b1, 1'b0, b[0], 1'b0);
			wr({9{16'hc396}}, !b[0], 1'b0, 1'b1, 2 - b);
			chk(144'(nlow), 144'h8);
			chk(144'(nal), 144'h1);
			chk(144'(nblk != 0), 144'(b));
			chk(144'({clr_bit, stat_bit}), 144'h3);
			@(negedge clk_i);
			err_clr = 1'b1;
			@(negedge clk_i);
			err_clr = 1'b0;
			repeat (4) @(negedge clk_i);
			chk(144'({clr_bit, stat_bit}), 144'h0);
		end
		$display("t_err finished");
	endtask : t_err

	// CRC off ignores bad CRC; fixed chop and fixed full burst without per-command choice
	task automatic t_off();
		cfg(WCRC_X8, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		wr({9{16'h1e87}}, 1'b1, 1'b1, 1'b1, 1);
		chk(144'(nlow), 144'h0);
		cfg(WCRC_X4, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
		wr({9{16'h7b24}}, 1'b0, 1'b1, 1'b0, 1);
		cfg(WCRC_X16, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		wr({9{16'he1d8}}, 1'b1, 1'b0, 1'b0, 1);
		$display("t_off finished");
	endtask : t_off

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (20) @(negedge clk_i);
		rstn_i = 1'b1;
		t_map();
		t_err();
		t_off();
		stop_test();
	end
endmodule : tb_top
